//--- verilog/mbs_sram_map.vh
/*
 * shared constants of the multibank sram: sizes, address fields, master slots, bus codes.
 * assumes byte addressing over a 512 KB window and a 32-bit data path.
 */
`ifndef MBS_SRAM_MAP_VH
`define MBS_SRAM_MAP_VH

// ==========================================================================
// geometry
// ==========================================================================
`define MBS_NUM_BANKS    4          // sub-blocks of 128 KB
`define MBS_NUM_MASTERS  8          // bus masters that reach the memory
`define MBS_MIDX_W       3          // width of a master index
`define MBS_ADDR_W       19         // 512 KB byte window
`define MBS_BANK_LSB     17         // addr[18:17] picks the sub-block
`define MBS_SEG_LSB      15         // addr[16:15] picks the 32 KB segment
`define MBS_WIDX_W       15         // addr[16:2] picks the word in a sub-block
`define MBS_BANK_WORDS   32768      // 128 KB / 4
`define MBS_AON_BANK     3          // sub-block kept in the always-on domain

// ==========================================================================
// master slots
// ==========================================================================
`define MBS_M_SYSBUS     0          // processor system bus
`define MBS_M_ICODE      1          // processor instruction bus
`define MBS_M_DCODE      2          // processor data bus
`define MBS_M_HOSTBR     3          // host_bridge_controller
`define MBS_M_CFGDMA     4          // configuration dma
`define MBS_M_VOICEDMA   5          // voice dma
`define MBS_M_SYSDMA     6          // system dma
`define MBS_M_FUSION     7          // fusion_engine

// ==========================================================================
// bus codes
// ==========================================================================
`define MBS_HSIZE_BYTE   3'h0
`define MBS_HSIZE_HALF   3'h1
`define MBS_HRESP_OKAY   1'h0
`define MBS_HRESP_ERROR  1'h1

`endif

//--- verilog/mbs_bank.v
/*
 * one 128 KB sub-block: round-robin arbiter over held requests, word array,
 * power checks per 32 KB segment and the memory clock request.
 * assumes the top holds each master's request until granted and keeps hwdata stable.
 */
`timescale 1ns/1ps
`default_nettype none
`include "mbs_sram_map.vh"

module mbs_bank #(
    parameter IN_PROC = 1,                               // 1: lives in processor domain
    parameter WORDS   = `MBS_BANK_WORDS                  // words held by this sub-block
) (
    input  wire                                        clk,
    input  wire                                        rst_n,
    input  wire                                        proc_pwr_on,
    input  wire [3:0]                                  seg_lowpwr,
    input  wire                                        wake,
    input  wire [`MBS_NUM_MASTERS-1:0]                 pend,
    input  wire [`MBS_NUM_MASTERS*`MBS_ADDR_W-1:0]     addr_flat,
    input  wire [`MBS_NUM_MASTERS-1:0]                 wr,
    input  wire [`MBS_NUM_MASTERS*3-1:0]               size_flat,
    input  wire [`MBS_NUM_MASTERS*32-1:0]              wdata_flat,
    output wire [`MBS_NUM_MASTERS-1:0]                 grant,
    output wire                                        err,
    output reg  [31:0]                                 rdata_q,
    output reg  [3:0]                                  lp_evt_q,
    output reg                                         clk_en_q
);

    // ======================================================================
    // helpers
    // ======================================================================
    // round robin: first requester after the last winner
    function [`MBS_NUM_MASTERS-1:0] rr_pick;
        input [`MBS_NUM_MASTERS-1:0] req;
        input [`MBS_MIDX_W-1:0]      ptr;
        integer i;
        reg [`MBS_MIDX_W-1:0] k;
        reg found;
        begin
            rr_pick = {`MBS_NUM_MASTERS{1'b0}};
            found   = 1'b0;
            for (i = 1; i <= `MBS_NUM_MASTERS; i = i + 1) begin
                k = ptr + i[`MBS_MIDX_W-1:0];
                if (!found && req[k]) begin
                    rr_pick[k] = 1'b1;
                    found      = 1'b1;
                end
            end
        end
    endfunction

    // one-hot to index
    function [`MBS_MIDX_W-1:0] oh_idx;
        input [`MBS_NUM_MASTERS-1:0] oh;
        integer i;
        begin
            oh_idx = {`MBS_MIDX_W{1'b0}};
            for (i = 0; i < `MBS_NUM_MASTERS; i = i + 1) begin
                if (oh[i]) begin
                    oh_idx = i[`MBS_MIDX_W-1:0];
                end
            end
        end
    endfunction

    // byte lanes touched by a write of the given size
    function [3:0] lanes;
        input [2:0] size;
        input [1:0] a;
        begin
            case (size)
                `MBS_HSIZE_BYTE: lanes = 4'h1 << a;
                `MBS_HSIZE_HALF: lanes = a[1] ? 4'hC : 4'h3;
                default:         lanes = 4'hF;
            endcase
        end
    endfunction

    // ======================================================================
    // arbitration and checks
    // ======================================================================
    reg  [31:0]                 mem [0:WORDS-1];         // the sub-block storage
    reg  [`MBS_MIDX_W-1:0]      ptr_q;                   // last winner
    wire [`MBS_NUM_MASTERS-1:0] gnt_c;                   // one-hot winner this cycle
    wire [`MBS_MIDX_W-1:0]      sel;                     // winner index
    wire                        any;                     // someone is waiting
    wire [`MBS_ADDR_W-1:0]      a;                       // winner address
    wire [1:0]                  seg;                     // winner segment
    wire [`MBS_WIDX_W-1:0]      widx;                    // winner word
    wire [3:0]                  be;                      // winner byte lanes
    wire [31:0]                 wd;                      // winner write data
    wire                        power_bad;               // domain switched off
    wire                        lp_hit;                  // segment asleep or off
    wire                        do_acc;                  // real array access

    assign gnt_c     = rr_pick(pend, ptr_q);             // RULE8
    assign grant     = gnt_c;
    assign sel       = oh_idx(gnt_c);
    assign any       = |pend;
    assign a         = addr_flat[sel*`MBS_ADDR_W +: `MBS_ADDR_W];
    assign seg       = a[`MBS_SEG_LSB+1:`MBS_SEG_LSB];   // RULE2
    assign widx      = a[`MBS_SEG_LSB+1:2];
    assign be        = lanes(size_flat[sel*3 +: 3], a[1:0]);
    assign wd        = wdata_flat[sel*32 +: 32];
    assign power_bad = (IN_PROC != 0) && !proc_pwr_on;   // RULE3
    assign lp_hit    = seg_lowpwr[seg];
    // refused accesses never touch the array, so a sleeping macro is not disturbed
    assign err       = any & (power_bad | lp_hit);
    assign do_acc    = any & ~err;

    // array writes, no reset on storage
    always @(posedge clk) begin
        if (do_acc && wr[sel]) begin
            if (be[0]) mem[widx][7:0]   <= wd[7:0];
            if (be[1]) mem[widx][15:8]  <= wd[15:8];
            if (be[2]) mem[widx][23:16] <= wd[23:16];
            if (be[3]) mem[widx][31:24] <= wd[31:24];
        end
    end

    // read data, events, pointer and clock request
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_q  <= 32'h0000_0000;
            lp_evt_q <= 4'h0;
            ptr_q    <= {`MBS_MIDX_W{1'b1}};
            clk_en_q <= 1'b0;
        end else begin
            if (do_acc && !wr[sel]) begin
                rdata_q <= mem[widx];
            end
            // one pulse per access that lands on a sleeping segment
            lp_evt_q <= (any && lp_hit) ? (4'h1 << seg) : 4'h0;  // RULE4
            if (any) begin
                ptr_q <= sel;
            end
            // clock is wanted only while work is arriving or waiting
            clk_en_q <= wake | any;                      // RULE7
        end
    end

endmodule

`default_nettype wire

//--- verilog/mbs_sram_top.v
/*
 * multibank on-chip sram: four 128 KB sub-blocks, eight bus masters, each
 * master with its own slave port, per-segment power checks and clock gating.
 * assumes all masters run on clk, follow bus-lite rules and stay idle after an error.
 */
`timescale 1ns/1ps
`default_nettype none
`include "mbs_sram_map.vh"

// What this block does
// RULE1: four 128 KB sub-blocks, concurrent access each
// RULE2: each sub-block split into four 32 KB segments
// RULE3: three sub-blocks need processor power to answer
// RULE4: access to sleeping segment raises an event
// RULE5: fourth sub-block always answers, always-on domain
// RULE6: eight masters reach the memory
// RULE7: memory clock off while no activity
// RULE8: arbitrate collisions, losers wait with wait states
module mbs_sram_top (
    input  wire                                      clk,
    input  wire                                      rst_n,
    input  wire                                      proc_pwr_on,
    input  wire [4*`MBS_NUM_BANKS-1:0]               seg_lowpwr,
    input  wire [`MBS_NUM_MASTERS-1:0]               hsel,
    input  wire [`MBS_NUM_MASTERS*2-1:0]             htrans,
    input  wire [`MBS_NUM_MASTERS*`MBS_ADDR_W-1:0]   haddr,
    input  wire [`MBS_NUM_MASTERS-1:0]               hwrite,
    input  wire [`MBS_NUM_MASTERS*3-1:0]             hsize,
    input  wire [`MBS_NUM_MASTERS*32-1:0]            hwdata,
    output wire [`MBS_NUM_MASTERS-1:0]               hready_out,
    output wire [`MBS_NUM_MASTERS-1:0]               hresp,
    output reg  [`MBS_NUM_MASTERS*32-1:0]            hrdata,
    output wire [`MBS_NUM_BANKS-1:0]                 mem_clk_en,
    output wire [4*`MBS_NUM_BANKS-1:0]               lp_access_evt
);

    localparam NM = `MBS_NUM_MASTERS;
    localparam NB = `MBS_NUM_BANKS;
    localparam AW = `MBS_ADDR_W;

    // ======================================================================
    // per-master held requests
    // ======================================================================
    reg  [NM-1:0]      pend_q;                  // address taken, not yet served
    reg  [NM-1:0]      err_q;                   // first cycle of an error answer
    reg  [NM-1:0]      err2_q;                  // second cycle of an error answer
    reg  [NM*AW-1:0]   addr_q;                  // held addresses
    reg  [NM-1:0]      wr_q;                    // held directions
    reg  [NM*3-1:0]    size_q;                  // held sizes
    reg  [NM*2-1:0]    pbank_q;                 // sub-block each master waits on
    reg  [NM-1:0]      acc;                     // address phase taken this cycle
    reg  [NM*2-1:0]    rbank_q;                 // sub-block that answered each master last
    reg  [NM-1:0]      gnt_any;                 // master served by some sub-block
    reg  [NM-1:0]      gnt_err;                 // master refused by its sub-block
    reg  [NB*NM-1:0]   bank_pend;               // held requests sorted per sub-block
    reg  [NB-1:0]      wake;                    // new work heading for a sub-block
    wire [NB*NM-1:0]   gnt_all;                 // grants of all sub-blocks
    wire [NB-1:0]      err_all;                 // refusal flags of all sub-blocks
    wire [NB*32-1:0]   rdata_all;               // read words of all sub-blocks

    integer m;                                  // loop index, request sorting
    integer b;                                  // loop index, request sorting
    integer gm;                                 // loop index, grant folding
    integer gb;                                 // loop index, grant folding
    integer s;                                  // loop index, held request capture
    integer h;                                  // loop index, read data steering

    // ======================================================================
    // helpers
    // ======================================================================
    // sub-block number carried in a byte address
    function [1:0] bank_of;
        input [AW-1:0] ad;
        begin
            bank_of = ad[`MBS_BANK_LSB+1:`MBS_BANK_LSB];        // RULE1
        end
    endfunction

    // ======================================================================
    // handshake outputs
    // ======================================================================
    // a master is ready unless it waits or is in the first error cycle
    assign hready_out = ~pend_q & ~err_q;                       // RULE8
    // error answer lasts two cycles, the first one with ready low
    assign hresp      = err_q | err2_q;

    // ======================================================================
    // request sorting
    // ======================================================================
    // bit 1 of each htrans pair marks nonseq or seq; idle and busy are ignored.
    // a held request goes only to the sub-block that it addressed, so the
    // four sub-blocks work side by side without seeing each other's masters.
    always @* begin
        acc       = {NM{1'b0}};
        bank_pend = {(NB*NM){1'b0}};
        wake      = {NB{1'b0}};
        for (m = 0; m < NM; m = m + 1) begin
            // every master owns a port of its own
            acc[m] = hready_out[m] & hsel[m] & htrans[2*m+1];   // RULE6
            for (b = 0; b < NB; b = b + 1) begin
                // waiting masters sorted per sub-block
                bank_pend[b*NM+m] = pend_q[m] & (pbank_q[2*m +: 2] == b[1:0]);
                // a new address phase asks for the memory clock one cycle early
                if (acc[m] && (bank_of(haddr[m*AW +: AW]) == b[1:0])) begin
                    wake[b] = 1'b1;                             // RULE7
                end
            end
        end
    end

    // ======================================================================
    // grant folding
    // ======================================================================
    // kept apart from the sorting above so that no process reads what it
    // feeds into the sub-blocks; only one sub-block can grant a master
    always @* begin
        gnt_any = {NM{1'b0}};
        gnt_err = {NM{1'b0}};
        for (gm = 0; gm < NM; gm = gm + 1) begin
            for (gb = 0; gb < NB; gb = gb + 1) begin
                if (gnt_all[gb*NM+gm]) begin
                    // served, possibly with a refusal
                    gnt_any[gm] = 1'b1;
                    gnt_err[gm] = gnt_err[gm] | err_all[gb];
                end
            end
        end
    end

    // ======================================================================
    // held requests
    // ======================================================================
    // the address phase is taken into registers so that a losing master
    // may keep waiting while its bus lines already move on
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pend_q  <= {NM{1'b0}};
            err_q   <= {NM{1'b0}};
            err2_q  <= {NM{1'b0}};
            addr_q  <= {(NM*AW){1'b0}};
            wr_q    <= {NM{1'b0}};
            size_q  <= {(NM*3){1'b0}};
            pbank_q <= {(NM*2){1'b0}};
            rbank_q <= {(NM*2){1'b0}};
        end else begin
            // served requests leave, new ones arrive; both never hit one master
            pend_q <= (pend_q & ~gnt_any) | acc;                // RULE8
            // refusal: first cycle ready low, second cycle ready high
            err_q  <= gnt_err;                                  // RULE3
            err2_q <= err_q;
            for (s = 0; s < NM; s = s + 1) begin
                if (acc[s]) begin
                    // capture the address phase
                    addr_q[s*AW +: AW] <= haddr[s*AW +: AW];
                    wr_q[s]            <= hwrite[s];
                    size_q[3*s +: 3]   <= hsize[3*s +: 3];
                    pbank_q[2*s +: 2]  <= bank_of(haddr[s*AW +: AW]);
                end
                if (gnt_any[s]) begin
                    // remember whose read word this master must see
                    rbank_q[2*s +: 2] <= pbank_q[2*s +: 2];
                end
            end
        end
    end

    // ======================================================================
    // read data steering
    // ======================================================================
    // each master sees the read register of the sub-block that served it;
    // the word is only meaningful in the cycle that ends its data phase
    always @* begin
        hrdata = {(NM*32){1'b0}};
        for (h = 0; h < NM; h = h + 1) begin
            hrdata[h*32 +: 32] = rdata_all[rbank_q[2*h +: 2]*32 +: 32];
        end
    end

    // ======================================================================
    // sub-blocks
    // ======================================================================
    // four independent sub-blocks, each with its own arbiter and array;
    // the last one stays in the always-on domain and ignores processor power
    genvar g;
    generate
        for (g = 0; g < NB; g = g + 1) begin : bank_g
            mbs_bank #(
                .IN_PROC ((g == `MBS_AON_BANK) ? 0 : 1),        // RULE5
                .WORDS   (`MBS_BANK_WORDS)
            ) u_bank (                                          // RULE1
                .clk         (clk),
                .rst_n       (rst_n),
                .proc_pwr_on (proc_pwr_on),
                .seg_lowpwr  (seg_lowpwr[4*g +: 4]),
                .wake        (wake[g]),
                .pend        (bank_pend[g*NM +: NM]),
                .addr_flat   (addr_q),
                .wr          (wr_q),
                .size_flat   (size_q),
                .wdata_flat  (hwdata),
                .grant       (gnt_all[g*NM +: NM]),
                .err         (err_all[g]),
                .rdata_q     (rdata_all[g*32 +: 32]),
                .lp_evt_q    (lp_access_evt[4*g +: 4]),
                .clk_en_q    (mem_clk_en[g])
            );
        end
    endgenerate

endmodule

`default_nettype wire

//--- bench/mbs_sram_sva.sv
/* port checker for the multibank sram.
   assumes a bind onto mbs_sram_top in one clock domain. */
`timescale 1ns/1ps
`default_nettype none
module mbs_sram_sva (
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic        proc_pwr_on,
    input wire logic [15:0] seg_lowpwr,
    input wire logic [7:0]  hsel,
    input wire logic [15:0] htrans,
    input wire logic [7:0]  hready_out,
    input wire logic [7:0]  hresp,
    input wire logic [3:0]  mem_clk_en,
    input wire logic [15:0] lp_access_evt
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    logic [3:0] idle_q; // cycles with no master selected, saturating
    always_ff @(posedge clk or negedge rst_n)
        if (!rst_n) idle_q <= 4'h0;
        else if (|hsel) idle_q <= 4'h0;
        else if (idle_q != 4'hF) idle_q <= idle_q + 4'h1;
    a_clk_off_idle: assert property (idle_q == 4'hF |-> mem_clk_en == 4'h0)
        else $error("memory clock on while idle");
    a_clk_on_access: assert property (hsel[0] && htrans[1] |-> ##[0:2] |mem_clk_en)
        else $error("memory clock not restored");
    a_evt_needs_lp: assert property ((lp_access_evt & ~$past(seg_lowpwr) & ~$past(seg_lowpwr, 2)) == 16'h0)
        else $error("event on awake segment");
    a_evt_needs_req: assert property (|lp_access_evt |-> $past(|hsel) || $past(|hsel, 2))
        else $error("event without access");
    a_err_needs_off: assert property (|(hresp & hready_out) |->
        !$past(proc_pwr_on, 2) || ($past(seg_lowpwr, 2) != 16'h0))
        else $error("error while powered");
    a_err_first_wait: assert property ($rose(hresp[0]) |-> !hready_out[0] ##1 hready_out[0] && hresp[0])
        else $error("error response not two cycles");
    a_wait_m1: assert property ($fell(hready_out[1]) |-> ##[1:16] hready_out[1])
        else $error("master one starved");
    a_wait_m2: assert property ($fell(hready_out[2]) |-> ##[1:16] hready_out[2])
        else $error("master two starved");
endmodule
`default_nettype wire

//--- bench/mbs_ahb_masters.sv
/* model of the eight bus masters on the far side.
   assumes one outstanding transfer per master. */
`timescale 1ns/1ps
`default_nettype none
module mbs_ahb_masters (
    input  wire logic [7:0]   hready_out,
    input  wire logic [7:0]   hresp,
    input  wire logic [255:0] hrdata,
    input  wire logic         clk,
    output logic      [7:0]   hsel,
    output logic      [15:0]  htrans,
    output logic      [151:0] haddr,
    output logic      [7:0]   hwrite,
    output logic      [23:0]  hsize,
    output logic      [255:0] hwdata
);
    logic [32:0] res;    // response and read data of the last finished transfer
    event        res_ev; // fires when res holds a new result of a transfer with n set
    initial {hsel, htrans, haddr, hwrite, hsize, hwdata} = '0;
    // one word transfer; released lines show inverted data, not stale values
    task automatic xfer(input int m, input logic [18:0] a, input logic w,
                        input logic [31:0] d, input logic n);
        @(posedge clk);
        hsel[m] <= 1'b1;
        htrans[2*m +: 2] <= 2'h2;
        haddr[19*m +: 19] <= a;
        hwrite[m] <= w;
        hsize[3*m +: 3] <= 3'h2;
        do @(posedge clk); while (hready_out[m] !== 1'b1);
        hsel[m] <= 1'b0;
        htrans[2*m +: 2] <= 2'h0;
        haddr[19*m +: 19] <= ~a;
        hwdata[32*m +: 32] <= d;
        do @(posedge clk); while (hready_out[m] !== 1'b1);
        res = {hresp[m], hrdata[32*m +: 32]};
        hwdata[32*m +: 32] <= ~d;
        if (n) ->res_ev;
    endtask
endmodule
`default_nettype wire

//--- bench/testbench.sv
/* self-checking bench for mbs_sram_top.
   assumes 200 MHz clock and the master model beside it. */
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic        clk, rst_n, pwr;
    logic [15:0] lp, evt_seen;
    logic [7:0]  hsel, hwrite, hready_out, hresp;
    logic [15:0] htrans, lp_access_evt;
    logic [151:0] haddr;
    logic [23:0] hsize;
    logic [255:0] hwdata, hrdata;
    logic [3:0]  mem_clk_en;
    logic [33:0] exp_q[$], note; // {data checked, resp, data}
    logic [31:0] dat[4];
    logic [18:0] ad[4];
    int          errors, check_count, seed;
    initial begin clk = 0; forever #2.5 clk = ~clk; end
    mbs_sram_top DUT (.clk(clk), .rst_n(rst_n), .proc_pwr_on(pwr), .seg_lowpwr(lp),
        .hsel(hsel), .htrans(htrans), .haddr(haddr), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready_out(hready_out), .hresp(hresp), .hrdata(hrdata),
        .mem_clk_en(mem_clk_en), .lp_access_evt(lp_access_evt));
    mbs_ahb_masters p (.clk(clk), .hready_out(hready_out), .hresp(hresp), .hrdata(hrdata),
        .hsel(hsel), .htrans(htrans), .haddr(haddr), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata));
    task check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            errors++;
            $display("BAD %0t seen %h want %h", $time, seen, exp);
        end
    endtask
    task report_and_stop;
        $display("errors %0d checks %0d", errors, check_count);
        if (errors == 0 && check_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task go(input int m, input logic [18:0] a, input logic w, input logic [31:0] d,
            input logic [33:0] e);
        exp_q.push_back(e);
        p.xfer(m, a, w, d, 1'b1);
    endtask
    // result watcher: oldest note against what the master saw
    always @(p.res_ev) begin
        note = exp_q.pop_front();
        check({31'h0, p.res[32]}, {31'h0, note[32]});
        if (note[33]) check(p.res[31:0], note[31:0]);
    end
    always @(posedge clk) evt_seen <= evt_seen | lp_access_evt;
    initial begin #50000; errors++; report_and_stop; end
    initial begin
        rst_n = 0; pwr = 1; lp = 0; evt_seen = 0; seed = 32'hf777f547;
        repeat (8) @(posedge clk);
        rst_n <= 1;
        for (int b = 0; b < 4; b++) begin
            dat[b] = $random(seed);
            ad[b] = {b[1:0], b[1:0], dat[b][12:0], 2'h0};
            go(b, ad[b], 1'b1, dat[b], 34'h0);
        end
        for (int b = 0; b < 4; b++) go(b + 4, ad[b], 1'b0, 0, {2'h2, dat[b]});
        $display("bank test done");
        fork // same-edge collision on one bank
            go(1, ad[2] ^ 19'h4, 1'b1, ~dat[2], 34'h0);
            go(2, ad[2] ^ 19'h8, 1'b1, dat[2] + 1, 34'h0);
        join
        go(3, ad[2] ^ 19'h4, 1'b0, 0, {2'h2, ~dat[2]});
        go(5, ad[2] ^ 19'h8, 1'b0, 0, {2'h2, dat[2] + 32'h1});
        $display("collision test done");
        lp <= 16'h0020;
        p.xfer(6, {2'h1, 2'h1, 15'h40}, 1'b0, 0, 1'b0);
        repeat (3) @(posedge clk);
        check({16'h0, evt_seen}, 32'h0020);
        lp <= 16'h0;
        $display("sleep test done");
        pwr <= 0;
        go(0, ad[0], 1'b0, 0, {2'h1, 32'h0});
        go(0, ad[3], 1'b0, 0, {2'h2, dat[3]});
        pwr <= 1;
        $display("power test done");
        repeat (20) @(posedge clk);
        check({28'h0, mem_clk_en}, 32'h0);
        $display("gating test done");
        report_and_stop;
    end
endmodule
bind mbs_sram_top mbs_sram_sva u_sva (.clk(clk), .rst_n(rst_n), .proc_pwr_on(proc_pwr_on),
    .seg_lowpwr(seg_lowpwr), .hsel(hsel), .htrans(htrans), .hready_out(hready_out),
    .hresp(hresp), .mem_clk_en(mem_clk_en), .lp_access_evt(lp_access_evt));
`default_nettype wire
